// ---- include/pd_regs_pkg.sv ----
package pd_regs_pkg;
   // ****************************************
   // Register indices (byte address = 4 * index)
   // ****************************************
   localparam logic [7:0] IDX_STATUS = 8'h41;
   localparam logic [7:0] IDX_FLAGS = 8'h42;
   localparam logic [7:0] IDX_FIFO = 8'h43;
   localparam logic [7:0] IDX_IRQ_EN = 8'h50;
   localparam logic [7:0] IDX_IRQ_CLR = 8'h51;

   // ****************************************
   // Status field positions
   // ****************************************
   localparam int ST_OCP = 0;
   localparam int ST_OVERHEAT = 1;
   localparam int ST_TX_FULL = 2;
   localparam int ST_TX_EMPTY = 3;
   localparam int ST_RX_FULL = 4;
   localparam int ST_RX_EMPTY = 5;

   // ****************************************
   // Interrupt flag positions
   // ****************************************
   localparam int IRQ_CC_LEVEL = 0;
   localparam int IRQ_COLLISION = 1;
   localparam int IRQ_WAKE = 2;
   localparam int IRQ_ALERT = 3;
   localparam int IRQ_COMP = 5;
   localparam int IRQ_ACTIVITY = 6;
   localparam int IRQ_VBUS = 7;

   // ****************************************
   // Asynchronous input positions in the synchroniser
   // ****************************************
   localparam int AS_VBUS = 0;
   localparam int AS_ACTIVITY = 1;
   localparam int AS_COMP = 2;
   localparam int AS_WAKE = 3;
   localparam int AS_OVERHEAT = 4;
   localparam int AS_OCP = 5;
   localparam int AS_LEVEL0 = 6;
   localparam int AS_LEVEL1 = 7;
   localparam int AS_W = 8;

   // ****************************************
   // Reset values and flag mask
   // ****************************************
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] FIFO_RESET = 8'h00;
   localparam logic [7:0] FLAG_MASK = 8'hEF;
   localparam logic [7:0] IRQ_EN_RESET = 8'hEF;
endpackage

// ---- rtl/pd_status_interrupt_fifo_regs.sv ----
// Implementation choice: the APB register port.
`timescale 1ns/1ps
// Overview of operation
// - Status bit 2 reads 1 while the transmit FIFO is full.
// - Status bit 1 reads 1 while the device is judged overheated.
// - Status bit 0 reads 1 while a VCONN over-current or short is flagged.
// - Flag bit 7 sets on every VBUS threshold crossing, either direction.
// - Flag bit 6 sets when activity appears on the CC line.
// - Flag bit 5 sets when the comparator result changes.
// - Flag bit 3 sets on a transmit or receive FIFO full error.
// - Flag bit 2 sets when CC voltage shows a partner attaching.
// - Flag bit 1 sets when reception and transmission collide.
// - Flag bit 0 sets when the CC level category changes.
// - FIFO port write pushes transmit byte unless the transmit FIFO is full; read pops receive byte unless the receive FIFO is empty.
module pd_status_interrupt_fifo_regs #(
   parameter int ADDR_W = 10
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Asynchronous analog detector levels
   input wire logic vbus_ok,
   input wire logic cc_activity,
   input wire logic comp_high,
   input wire logic wake_detect,
   input wire logic overheat_flag,
   input wire logic vconn_overcurrent_flag,
   input wire logic [1:0] cc_level,
   // Protocol events on this clock
   input wire logic collision,
   input wire logic rx_overflow,
   // Transmit FIFO
   output logic tx_push,
   output logic [7:0] tx_data,
   input wire logic tx_full,
   input wire logic tx_empty,
   // Receive FIFO
   output logic rx_pop,
   input wire logic [7:0] rx_data,
   input wire logic rx_full,
   input wire logic rx_empty,
   // Interrupt
   output logic irq
);
   // ****************************************
   // Elaboration checks
   // ****************************************
   if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must be 10 to 32");
   end

   // ****************************************
   // Declarations
   // ****************************************
   logic [pd_regs_pkg::AS_W-1:0] s1, s2, s3, filt, prev;
   logic [7:0] flags, irq_en, ev, clr, next_flags;
   logic access, done;
   logic rd_data_ok;
   logic [7:0] rd_byte;

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0] idx);
      hit = (a[1:0] == 2'b00) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
   endfunction

   // ****************************************
   // Input synchroniser
   // ****************************************
   // A bit is accepted only when stages two and three agree
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         filt <= '0;
         prev <= '0;
      end else begin
         s1 <= {cc_level, vconn_overcurrent_flag, overheat_flag,
                wake_detect, comp_high, cc_activity, vbus_ok};
         s2 <= s1;
         s3 <= s2;
         filt <= (s2 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
         prev <= filt;
      end
   end

   // ****************************************
   // APB handshake
   // ****************************************
   assign access = psel && penable && !pready;
   assign done = psel && penable && pready;

   always_comb begin
      rd_byte = 8'h00;
      rd_data_ok = 1'b1;
      if (hit(paddr, pd_regs_pkg::IDX_STATUS)) begin
         rd_byte[pd_regs_pkg::ST_OCP] = filt[pd_regs_pkg::AS_OCP];
         rd_byte[pd_regs_pkg::ST_OVERHEAT] =
            filt[pd_regs_pkg::AS_OVERHEAT];
         rd_byte[pd_regs_pkg::ST_TX_FULL] = tx_full;
         rd_byte[pd_regs_pkg::ST_TX_EMPTY] = tx_empty;
         rd_byte[pd_regs_pkg::ST_RX_FULL] = rx_full;
         rd_byte[pd_regs_pkg::ST_RX_EMPTY] = rx_empty;
      end else if (hit(paddr, pd_regs_pkg::IDX_FLAGS)) begin
         rd_byte = flags;
      end else if (hit(paddr, pd_regs_pkg::IDX_FIFO)) begin
         // An empty receive FIFO reads as its reset value
         rd_byte = rx_empty ? pd_regs_pkg::FIFO_RESET : rx_data;
      end else if (hit(paddr, pd_regs_pkg::IDX_IRQ_EN)) begin
         rd_byte = irq_en;
      end else if (!hit(paddr, pd_regs_pkg::IDX_IRQ_CLR)) begin
         rd_data_ok = 1'b0;
      end
   end

   // Answer in the second access cycle; data is captured a cycle early
   // so a read-clear or pop can act on exactly what was returned.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end else begin
         pready <= access;
         if (access) begin
            prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr <= !rd_data_ok;
         end
      end
   end

   // ****************************************
   // Interrupt events
   // ****************************************
   always_comb begin
      ev = 8'h00;
      ev[pd_regs_pkg::IRQ_VBUS] = filt[pd_regs_pkg::AS_VBUS] ^
                                  prev[pd_regs_pkg::AS_VBUS];
      ev[pd_regs_pkg::IRQ_ACTIVITY] = filt[pd_regs_pkg::AS_ACTIVITY] &
                                      ~prev[pd_regs_pkg::AS_ACTIVITY];
      ev[pd_regs_pkg::IRQ_COMP] = filt[pd_regs_pkg::AS_COMP] ^
                                  prev[pd_regs_pkg::AS_COMP];
      ev[pd_regs_pkg::IRQ_ALERT] = rx_overflow ||
         (done && pwrite && hit(paddr, pd_regs_pkg::IDX_FIFO)
          && tx_full);
      ev[pd_regs_pkg::IRQ_WAKE] = filt[pd_regs_pkg::AS_WAKE] &
                                  ~prev[pd_regs_pkg::AS_WAKE];
      ev[pd_regs_pkg::IRQ_COLLISION] = collision;
      ev[pd_regs_pkg::IRQ_CC_LEVEL] =
         (filt[pd_regs_pkg::AS_LEVEL0] ^ prev[pd_regs_pkg::AS_LEVEL0]) |
         (filt[pd_regs_pkg::AS_LEVEL1] ^ prev[pd_regs_pkg::AS_LEVEL1]);
   end

   always_comb begin
      clr = 8'h00;
      if (done && !pwrite && hit(paddr, pd_regs_pkg::IDX_FLAGS)) begin
         clr = prdata[7:0];
      end else if (done && pwrite &&
                   hit(paddr, pd_regs_pkg::IDX_IRQ_CLR)) begin
         clr = pwdata[7:0];
      end
   end

   // A new event in the clearing cycle survives: set beats clear
   assign next_flags = ((flags & ~clr) | ev) & pd_regs_pkg::FLAG_MASK;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flags <= pd_regs_pkg::FLAGS_RESET;
      end else begin
         flags <= next_flags;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_en <= pd_regs_pkg::IRQ_EN_RESET;
      end else if (done && pwrite &&
                   hit(paddr, pd_regs_pkg::IDX_IRQ_EN)) begin
         irq_en <= pwdata[7:0] & pd_regs_pkg::FLAG_MASK;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(flags & irq_en);
      end
   end

   // ****************************************
   // FIFO port
   // ****************************************
   // A write while full is not pushed and raises the alert flag; tx_data still takes the byte
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_push <= 1'b0;
         tx_data <= pd_regs_pkg::FIFO_RESET;
         rx_pop <= 1'b0;
      end else begin
         tx_push <= done && pwrite && !tx_full &&
                    hit(paddr, pd_regs_pkg::IDX_FIFO);
         rx_pop <= done && !pwrite && !rx_empty &&
                   hit(paddr, pd_regs_pkg::IDX_FIFO);
         if (done && pwrite && hit(paddr, pd_regs_pkg::IDX_FIFO)) begin
            tx_data <= pwdata[7:0];
         end
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence s_access;
      psel && penable && !pready;
   endsequence

   sequence s_fifo_wr;
      done && pwrite && hit(paddr, pd_regs_pkg::IDX_FIFO);
   endsequence

   sequence s_flag_rd;
      done && !pwrite && hit(paddr, pd_regs_pkg::IDX_FLAGS);
   endsequence

   a_apb_answer_time: assert property (s_access |=> pready ##1 !pready)
      else $error("pready not one cycle after access start");

   a_status_fields: assert property (
      (s_access ##0 (!pwrite && hit(paddr, pd_regs_pkg::IDX_STATUS)))
      |=> prdata[2:0] == {$past(tx_full),
                          $past(filt[pd_regs_pkg::AS_OVERHEAT]),
                          $past(filt[pd_regs_pkg::AS_OCP])})
      else $error("status bits do not match sources");

   a_vbus_cross: assert property (
      $changed(filt[pd_regs_pkg::AS_VBUS])
      |=> flags[pd_regs_pkg::IRQ_VBUS])
      else $error("vbus crossing flag missed");

   a_wake_flag: assert property (
      $rose(filt[pd_regs_pkg::AS_WAKE]) |=> flags[pd_regs_pkg::IRQ_WAKE])
      else $error("wake flag missed");

   a_flag_read_clear: assert property (
      (s_flag_rd ##0 (ev == 8'h00))
      |=> flags == ($past(flags) & ~$past(prdata[7:0])))
      else $error("flag read did not clear returned bits");

   a_flag_sticky: assert property (
      (clr == 8'h00) |=> (flags & $past(flags)) == $past(flags))
      else $error("flag dropped without a clear");

   a_irq_level: assert property (
      (flags & irq_en) != 8'h00 |=> irq ##0 1'b1 [*1])
      else $error("irq low with enabled flag set");

   a_irq_release: assert property (
      (flags & irq_en) == 8'h00 [*2] |-> !irq)
      else $error("irq high with no enabled flag");

   a_tx_push: assert property (
      (s_fifo_wr ##0 !tx_full)
      |=> tx_push && tx_data == $past(pwdata[7:0]) ##1 !tx_push)
      else $error("fifo write did not push one byte");

   a_rx_pop: assert property (
      (done && !pwrite && !rx_empty && hit(paddr, pd_regs_pkg::IDX_FIFO))
      |=> rx_pop ##1 !rx_pop)
      else $error("fifo read did not pop one byte");

   a_activity_rise: assert property (
      $rose(filt[pd_regs_pkg::AS_ACTIVITY])
      |=> flags[pd_regs_pkg::IRQ_ACTIVITY])
      else $error("activity flag missed");

   a_comp_change: assert property (
      $changed(filt[pd_regs_pkg::AS_COMP]) |=> flags[pd_regs_pkg::IRQ_COMP])
      else $error("comparator change flag missed");

   a_overflow_alert: assert property (
      rx_overflow |=> flags[pd_regs_pkg::IRQ_ALERT])
      else $error("overflow alert flag missed");

   a_full_write_alert: assert property (
      (s_fifo_wr ##0 tx_full) |=> flags[pd_regs_pkg::IRQ_ALERT])
      else $error("write to full fifo did not raise alert");

   a_collision_flag: assert property (
      collision |=> flags[pd_regs_pkg::IRQ_COLLISION])
      else $error("collision flag missed");

   a_level_change: assert property (
      $changed(filt[pd_regs_pkg::AS_LEVEL1:pd_regs_pkg::AS_LEVEL0])
      |=> flags[pd_regs_pkg::IRQ_CC_LEVEL])
      else $error("cc level change flag missed");

   a_set_wins: assert property (
      ev != 8'h00 |=> (flags & $past(ev)) == $past(ev))
      else $error("event lost in a clearing cycle");
endmodule

// ---- sim/fifo_model.sv ----
`timescale 1ns/1ps
// ****************************************
// Transmit and receive FIFO stand-in
// ****************************************
module fifo_model #(
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic tx_push,
   input wire logic [7:0] tx_data,
   input wire logic rx_pop,
   output logic tx_full,
   output logic tx_empty,
   output logic [7:0] rx_data,
   output logic rx_full,
   output logic rx_empty
);
   logic [7:0] txm [16];
   logic [7:0] rxm [16];
   int tn = 0;
   int rn = 0;
   int rp = 0;
   task automatic rx_put(input logic [7:0] b);
      rxm[rn] <= b;
      rn <= rn + 1;
      @(posedge clk);
   endtask
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tn <= 0;
         rp <= 0;
      end else begin
         if (tx_push && tn < DEPTH) begin
            txm[tn] <= tx_data;
            tn <= tn + 1;
         end
         if (rx_pop && rp < rn) begin
            rp <= rp + 1;
         end
      end
   end
   assign tx_full = (tn == DEPTH);
   assign tx_empty = (tn == 0);
   assign rx_full = (rn - rp == DEPTH);
   assign rx_empty = (rp == rn);
   // Drained head shows a moving pattern, so a stale byte cannot pass
   assign rx_data = rx_empty ? 8'(rp * 53) : rxm[rp];
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb;
   logic clk = 0;
   logic nrst = 0;
   logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [31:0] rd;
   // Detector levels idle low: no VCONN fault shows before supply is up
   logic [7:0] ain = 8'h00, tx_data, rx_data;
   logic collision = 0, rx_overflow = 0, tx_push, rx_pop, err;
   logic tx_full, tx_empty, rx_full, rx_empty;
   int mismatches = 0, n_tests = 0, cycles = 0;
   int ev_bit [9] = '{0, 0, 1, 2, 3, 6, 7, 4, 5};
   logic [7:0] ev_flag [9] = '{8'h80, 8'h80, 8'h40, 8'h20, 8'h04, 8'h01,
      8'h01, 8'h00, 8'h00};
   pd_status_interrupt_fifo_regs #(.ADDR_W(10)) DUT (.clk(clk),
      .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .vbus_ok(ain[pd_regs_pkg::AS_VBUS]),
      .cc_activity(ain[pd_regs_pkg::AS_ACTIVITY]),
      .comp_high(ain[pd_regs_pkg::AS_COMP]),
      .wake_detect(ain[pd_regs_pkg::AS_WAKE]),
      .overheat_flag(ain[pd_regs_pkg::AS_OVERHEAT]),
      .vconn_overcurrent_flag(ain[pd_regs_pkg::AS_OCP]),
      .cc_level(ain[pd_regs_pkg::AS_LEVEL1:pd_regs_pkg::AS_LEVEL0]),
      .collision(collision), .rx_overflow(rx_overflow),
      .tx_push(tx_push), .tx_data(tx_data), .tx_full(tx_full),
      .tx_empty(tx_empty), .rx_pop(rx_pop), .rx_data(rx_data),
      .rx_full(rx_full), .rx_empty(rx_empty), .irq(irq));
   fifo_model #(.DEPTH(4)) u_fifo (.clk(clk), .nrst(nrst),
      .tx_push(tx_push), .tx_data(tx_data), .rx_pop(rx_pop),
      .tx_full(tx_full), .tx_empty(tx_empty), .rx_data(rx_data),
      .rx_full(rx_full), .rx_empty(rx_empty));
   initial begin
      // Clock runs throughout, so it is up whenever wake is flagged
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ****************************************
   // APB master: hold until pready, one idle edge after release
   // ****************************************
   task automatic apb(input logic w, input logic [7:0] idx,
         input logic [7:0] wd);
      psel <= 1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask
   task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
      apb(0, idx, 8'h00);
      chk(rd, {24'h00_0000, exp});
   endtask
   task automatic rflags(input logic [7:0] exp);
      rchk(pd_regs_pkg::IDX_FLAGS, exp);
   endtask
   task automatic pulse(input int which);
      if (which == 0) collision <= 1;
      else rx_overflow <= 1;
      @(posedge clk);
      collision <= 0;
      rx_overflow <= 0;
      repeat (3) @(posedge clk);
   endtask
   task automatic t_reset();
      rchk(pd_regs_pkg::IDX_FLAGS, 8'h00);
      rchk(pd_regs_pkg::IDX_IRQ_EN, 8'hEF);
      rchk(pd_regs_pkg::IDX_STATUS, 8'h28);
      chk(irq, 0);
   endtask
   task automatic t_rx_pop();
      u_fifo.rx_put(8'hC3);
      u_fifo.rx_put(8'h3C);
      rchk(pd_regs_pkg::IDX_FIFO, 8'hC3);
      rchk(pd_regs_pkg::IDX_FIFO, 8'h3C);
      rchk(pd_regs_pkg::IDX_FIFO, 8'h00);
      for (int i = 0; i < 4; i++) u_fifo.rx_put(8'h50 + i);
      rchk(pd_regs_pkg::IDX_STATUS, 8'h18);
      for (int i = 0; i < 4; i++) begin
         rchk(pd_regs_pkg::IDX_FIFO, 8'h50 + i);
      end
   endtask
   task automatic t_tx_fill();
      for (int i = 0; i < 5; i++) apb(1, pd_regs_pkg::IDX_FIFO, 8'hA0 + i);
      for (int i = 0; i < 4; i++) chk(u_fifo.txm[i], 8'hA0 + i);
      chk(u_fifo.tn, 4);
      rchk(pd_regs_pkg::IDX_STATUS, 8'h24);
      rchk(pd_regs_pkg::IDX_FLAGS, 8'h08);
      pulse(1);
      rchk(pd_regs_pkg::IDX_FLAGS, 8'h08);
   endtask
   task automatic t_events();
      for (int i = 0; i < 9; i++) begin
         ain[ev_bit[i]] <= ~ain[ev_bit[i]];
         // Three sync flops plus edge detect settle well inside ten cycles
         repeat (10) @(posedge clk);
         chk(irq, ev_flag[i] != 0);
         rflags(ev_flag[i]);
         rchk(pd_regs_pkg::IDX_FLAGS, 8'h00);
         chk(irq, 0);
      end
      rchk(pd_regs_pkg::IDX_STATUS, 8'h27);
      pulse(0);
      chk(irq, 1);
      rchk(pd_regs_pkg::IDX_FLAGS, 8'h02);
   endtask
   task automatic t_mask_clear();
      apb(1, pd_regs_pkg::IDX_IRQ_EN, 8'h00);
      pulse(0);
      chk(irq, 0);
      apb(1, pd_regs_pkg::IDX_IRQ_CLR, 8'h02);
      rchk(pd_regs_pkg::IDX_FLAGS, 8'h00);
      apb(1, pd_regs_pkg::IDX_IRQ_EN, 8'hEF);
      apb(1, pd_regs_pkg::IDX_FLAGS, 8'hFF);
      rchk(pd_regs_pkg::IDX_FLAGS, 8'h00);
      rchk(8'hFF, 8'h00);
      chk(err, 1);
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         print_verdict();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1;
      repeat (8) @(posedge clk);
      t_reset();
      t_rx_pop();
      t_tx_fill();
      t_events();
      t_mask_clear();
      print_verdict();
   end
endmodule
